// *** src/cipher_seq_pkg.sv ***
package cipher_seq_pkg;
   // Instruction layout: {first byte, second byte, third byte low six bits}
   localparam int INSTR_W = 22;
   localparam int PC_W = 6;
   localparam int FIRST_HI = 21;
   localparam int FIRST_LO = 14;
   localparam int SECOND_HI = 13;
   localparam int SECOND_LO = 6;
   localparam int THIRD_HI = 5;
   localparam int THIRD_LO = 0;
   // Clock cycles per instruction
   localparam int CYCLES_PER_INSTR = 2;

   // Second byte fields
   localparam int FORM_BIT = 4;
   localparam int COND_HI = 3;
   localparam int COND_LO = 0;

   // Clock command bits, first byte
   localparam int CC_SRC_SEL = 7;
   localparam int CC_LR_CLOCK = 6;
   localparam int CC_LATCH_CLOCK = 5;
   localparam int CC_DOUBLE_ROT = 4;
   localparam int CC_KEY_LATCH = 3;
   localparam int CC_CD_LOAD = 2;
   localparam int CC_CD_CLOCK = 1;
   localparam int CC_IN_CLEAR = 0;
   // Clock command bits, second byte
   localparam int CC_OUT_CLEAR = 7;
   localparam int CC_OUT_CLOCK = 6;
   localparam int CC_STORE_IV = 5;

   // Multiplexer select bits
   localparam int MS_ONE = 7;
   localparam int MS_TWO_HI = 6;
   localparam int MS_TWO_LO = 5;
   localparam int MS_THREE = 4;
   localparam int MS_FOUR = 3;
   localparam int MS_FIVE_HI = 2;
   localparam int MS_FIVE_LO = 1;
   localparam int MS_SIX_HI = 0;
   localparam int MS_SIX_LO = 7;
   localparam int MS_THIRTEEN_HI = 6;
   localparam int MS_THIRTEEN_LO = 5;
   localparam logic [1:0] SEL_ILLEGAL = 2'h3;

   // Third byte argument bits
   localparam int ARG_ROT_RIGHT = 0;
   localparam int ARG_PAIR_HI = 2;
   localparam int ARG_PAIR_LO = 1;
   localparam int ARG_INT_SEL = 0;
   localparam int ARG_FORCE_FLAGS = 5;
   localparam int ARG_CFB_BYTE = 4;
   localparam int ARG_CFB_SINGLE = 3;
   localparam int ARG_SERIAL = 2;
   localparam int ARG_MASTER = 1;
   localparam int ARG_ENGAGED = 0;
   localparam int LOOP_W = 4;

   // Conditional operation codes
   localparam logic [3:0] OP_LOOP_LOAD = 4'h0;
   localparam logic [3:0] OP_LOOP_DEC = 4'h1;
   localparam logic [3:0] OP_CALL = 4'h2;
   localparam logic [3:0] OP_RETURN = 4'h3;
   localparam logic [3:0] OP_JUMP = 4'h4;
   localparam logic [3:0] OP_IN_NOT_FULL = 4'h5;
   localparam logic [3:0] OP_OUT_NOT_EMPTY = 4'h6;
   localparam logic [3:0] OP_FULL_EMPTY = 4'h7;
   localparam logic [3:0] OP_KEY_ORDER = 4'h8;
   localparam logic [3:0] OP_ROT_DIR = 4'h9;
   localparam logic [3:0] OP_PAIR = 4'ha;
   localparam logic [3:0] OP_IO_MODE = 4'hb;
   localparam logic [3:0] OP_CLEAR = 4'hc;
   localparam logic [3:0] OP_STEP = 4'hf;

   // Memory map of program store
   localparam int ROM_WORDS = 29;
   localparam int RAM_WORDS = 32;
   localparam int RAM_AW = 5;
   localparam int RAM_SEL_BIT = 5;
   localparam logic [5:0] ENTRY_CIPHER = 6'h00;
   localparam logic [5:0] ENTRY_IV_LOAD = 6'h06;
   localparam logic [5:0] ENTRY_PAR_KEY = 6'h0b;
   localparam logic [5:0] ENTRY_SER_KEY = 6'h10;

   // Software register map
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_CONTROL = 8'h04;
   localparam logic [7:0] REG_START = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RAM_ADDR = 8'h10;
   localparam logic [7:0] REG_RAM_DATA = 8'h14;
   localparam int CFG_KEY_ORDER = 7;
   localparam int CTL_RUN = 0;
   localparam int ST_ENGAGED = 0;
   localparam int ST_IN_FULL = 1;
   localparam int ST_OUT_EMPTY = 2;
   localparam int ST_MUX_ERR = 4;
   localparam int ST_CFB_ERR = 5;
   localparam int ST_RUN = 6;
   localparam int ST_PC_LO = 8;

   typedef enum logic [1:0] {
      SEQ_FETCH = 2'b01,
      SEQ_EXEC = 2'b10
   } seq_state_e;
endpackage : cipher_seq_pkg

// *** src/cipher_microsequencer_decoder.sv ***
module cipher_microsequencer_decoder (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic in_reg_write_i,
   input wire logic out_reg_read_i,
   output logic in_full_flag_o,
   output logic out_empty_flag_o,
   output logic cipher_src_sel_o,
   output logic cipher_lr_clock_o,
   output logic latch_clock_o,
   output logic double_rotate_o,
   output logic key_reg_latch_o,
   output logic key_cd_load_o,
   output logic key_cd_clock_o,
   output logic out_reg_clock_o,
   output logic store_iv_o,
   output logic rot_right_o,
   output logic rot_left_o,
   output logic mux_one_sel_o,
   output logic [1:0] mux_two_sel_o,
   output logic mux_three_sel_o,
   output logic mux_four_sel_o,
   output logic [1:0] mux_five_sel_o,
   output logic [1:0] mux_six_sel_o,
   output logic [1:0] mux_thirteen_sel_o,
   output logic [1:0] pair_addr_o,
   output logic internal_addr_sel_o,
   output logic [1:0] cfb_width_o,
   output logic serial_key_o,
   output logic force_master_input_o,
   output logic engaged_o,
   output logic error_o,
   output logic [5:0] pc_o
);

   localparam logic [5:0] PC_ONE = 6'h01;
   localparam logic [3:0] LOOP_ONE = 4'h1;

   // Fixed program store, first byte, second byte, third byte
   function automatic logic [21:0] rom_word(input logic [5:0] a);
      logic [23:0] w;
      w = 24'h000000;
      case (a)
         6'h00: w = 24'hc21f00;
         6'h01: w = 24'h421005;
         6'h02: w = 24'h521102;
         6'h03: w = 24'h421005;
         6'h04: w = 24'h521104;
         6'h05: w = 24'h421300;
         6'h06: w = 24'h010b03;
         6'h07: w = 24'h011a00;
         6'h08: w = 24'h001508;
         6'h09: w = 24'h003c00;
         6'h0a: w = 24'h00140a;
         6'h0b: w = 24'h010b03;
         6'h0c: w = 24'h011a00;
         6'h0d: w = 24'h00150d;
         6'h0e: w = 24'h081c00;
         6'h0f: w = 24'h00140f;
         6'h10: w = 24'h010b07;
         6'h11: w = 24'h00140c;
         6'h12: w = 24'h010c00;
         6'h13: w = 24'h071815;
         6'h14: w = 24'h021901;
         6'h15: w = 24'h001515;
         6'h16: w = 24'hc31201;
         6'h17: w = 24'h00171a;
         6'h18: w = 24'h001618;
         6'h19: w = 24'h00d415;
         6'h1a: w = 24'hc3d201;
         6'h1b: w = 24'h00171a;
         6'h1c: w = 24'h001418;
         default: w = 24'h000000;
      endcase
      return {w[23:8], w[5:0]};
   endfunction : rom_word

   // Two-bit select built from a high and low bit
   function automatic logic [1:0] sel2(input logic hi, input logic lo);
      return {hi, lo};
   endfunction : sel2

   cipher_seq_pkg::seq_state_e state_reg;
   logic [5:0] pc_reg;
   logic [5:0] ret_reg;
   logic [3:0] loop_reg;
   logic [21:0] instr_reg;
   logic [21:0] ram_mem [cipher_seq_pkg::RAM_WORDS];
   logic [4:0] ram_addr_reg;
   logic run_reg;
   logic [7:0] config_reg;
   logic in_full_reg;
   logic out_empty_reg;
   logic mux_err_reg;
   logic cfb_err_reg;
   logic [31:0] rdata_reg;
   logic [10:0] strobe_reg;
   logic [10:0] strobe_next;
   logic [12:0] msel_reg;
   logic rot_right_reg;
   logic rot_left_reg;
   logic [1:0] pair_reg;
   logic int_sel_reg;
   logic [1:0] cfb_reg;
   logic serial_reg;
   logic master_reg;
   logic engaged_reg;

   // Decode of the held instruction
   wire [7:0] first_b = instr_reg[cipher_seq_pkg::FIRST_HI:cipher_seq_pkg::FIRST_LO];
   wire [7:0] second_b = instr_reg[cipher_seq_pkg::SECOND_HI:cipher_seq_pkg::SECOND_LO];
   wire [5:0] third_b = instr_reg[cipher_seq_pkg::THIRD_HI:cipher_seq_pkg::THIRD_LO];
   wire [3:0] op = second_b[cipher_seq_pkg::COND_HI:cipher_seq_pkg::COND_LO];
   wire exec = run_reg && (state_reg == cipher_seq_pkg::SEQ_EXEC);
   wire clock_form = second_b[cipher_seq_pkg::FORM_BIT];
   wire cc_exec = exec && clock_form;
   wire ms_exec = exec && !clock_form;
   wire [5:0] pc_inc = pc_reg + PC_ONE;
   wire [3:0] loop_dec = loop_reg - LOOP_ONE;
   wire [21:0] fetch_word = pc_reg[cipher_seq_pkg::RAM_SEL_BIT] ?
      ram_mem[pc_reg[4:0]] : rom_word(pc_reg);

   wire [1:0] two_sel = sel2(first_b[cipher_seq_pkg::MS_TWO_HI],
                             first_b[cipher_seq_pkg::MS_TWO_LO]);
   wire [1:0] five_sel = sel2(first_b[cipher_seq_pkg::MS_FIVE_HI],
                              first_b[cipher_seq_pkg::MS_FIVE_LO]);
   wire [1:0] six_sel = sel2(first_b[cipher_seq_pkg::MS_SIX_HI],
                             second_b[cipher_seq_pkg::MS_SIX_LO]);
   wire [1:0] thirteen_sel = sel2(second_b[cipher_seq_pkg::MS_THIRTEEN_HI],
                                  second_b[cipher_seq_pkg::MS_THIRTEEN_LO]);
   wire mux_bad = ms_exec && ((two_sel == cipher_seq_pkg::SEL_ILLEGAL) ||
      (five_sel == cipher_seq_pkg::SEL_ILLEGAL) ||
      (six_sel == cipher_seq_pkg::SEL_ILLEGAL));
   wire [1:0] cfb_arg = sel2(third_b[cipher_seq_pkg::ARG_CFB_SINGLE],
                             third_b[cipher_seq_pkg::ARG_CFB_BYTE]);
   wire is_io = exec && (op == cipher_seq_pkg::OP_IO_MODE);
   wire is_clear = exec && (op == cipher_seq_pkg::OP_CLEAR);
   wire is_rot = exec && (op == cipher_seq_pkg::OP_ROT_DIR);
   wire is_pair = exec && (op == cipher_seq_pkg::OP_PAIR);
   wire cfb_bad = is_io && (cfb_arg == cipher_seq_pkg::SEL_ILLEGAL);
   wire force_flags = is_io && third_b[cipher_seq_pkg::ARG_FORCE_FLAGS];

   // Branch decision; unused codes simply step
   logic take_jump;
   logic [5:0] pc_next;
   always_comb begin
      take_jump = 1'b0;
      case (op)
         cipher_seq_pkg::OP_LOOP_DEC: take_jump = (loop_dec != 4'h0);
         cipher_seq_pkg::OP_CALL: take_jump = 1'b1;
         cipher_seq_pkg::OP_JUMP: take_jump = 1'b1;
         cipher_seq_pkg::OP_IN_NOT_FULL: take_jump = !in_full_reg;
         cipher_seq_pkg::OP_OUT_NOT_EMPTY: take_jump = !out_empty_reg;
         cipher_seq_pkg::OP_FULL_EMPTY: take_jump = in_full_reg && out_empty_reg;
         cipher_seq_pkg::OP_KEY_ORDER:
            take_jump = !config_reg[cipher_seq_pkg::CFG_KEY_ORDER];
         default: take_jump = 1'b0;
      endcase
      if (op == cipher_seq_pkg::OP_RETURN) begin
         pc_next = ret_reg;
      end else if (take_jump) begin
         pc_next = third_b;
      end else begin
         pc_next = pc_inc;
      end
   end

   // Clock command strobes, decoded in the execute phase, output for one cycle after it
   always_comb begin
      strobe_next = 11'h000;
      if (cc_exec) begin
         strobe_next = {first_b, second_b[7:5]};
      end
   end

   // Register bus decode
   wire wr_config = wr_i && (addr_i == cipher_seq_pkg::REG_CONFIG);
   wire wr_control = wr_i && (addr_i == cipher_seq_pkg::REG_CONTROL);
   wire wr_start = wr_i && (addr_i == cipher_seq_pkg::REG_START);
   wire wr_status = wr_i && (addr_i == cipher_seq_pkg::REG_STATUS);
   wire wr_ram_addr = wr_i && (addr_i == cipher_seq_pkg::REG_RAM_ADDR);
   wire wr_ram_data = wr_i && (addr_i == cipher_seq_pkg::REG_RAM_DATA);
   wire [31:0] status_word = {18'h00000, pc_reg, 1'b0, run_reg, cfb_err_reg,
      mux_err_reg, 1'b0, out_empty_reg, in_full_reg, engaged_reg};
   logic [31:0] read_mux;
   always_comb begin
      case (addr_i)
         cipher_seq_pkg::REG_CONFIG: read_mux = {24'h000000, config_reg};
         cipher_seq_pkg::REG_CONTROL: read_mux = {31'h00000000, run_reg};
         cipher_seq_pkg::REG_START: read_mux = {26'h0000000, pc_reg};
         cipher_seq_pkg::REG_STATUS: read_mux = status_word;
         cipher_seq_pkg::REG_RAM_ADDR: read_mux = {27'h0000000, ram_addr_reg};
         default: read_mux = 32'h00000000;
      endcase
   end

   // Sequencer: fetch then execute, so two cycles per instruction
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= cipher_seq_pkg::SEQ_FETCH;
         pc_reg <= cipher_seq_pkg::ENTRY_CIPHER;
         instr_reg <= 22'h000000;
      end else if (wr_start) begin
         state_reg <= cipher_seq_pkg::SEQ_FETCH;
         pc_reg <= wdata_i[5:0];
      end else if (run_reg) begin
         case (state_reg)
            cipher_seq_pkg::SEQ_FETCH: begin
               instr_reg <= fetch_word;
               state_reg <= cipher_seq_pkg::SEQ_EXEC;
            end
            cipher_seq_pkg::SEQ_EXEC: begin
               pc_reg <= pc_next;
               state_reg <= cipher_seq_pkg::SEQ_FETCH;
            end
            default: state_reg <= cipher_seq_pkg::SEQ_FETCH;
         endcase
      end
   end

   // Loop counter and single return slot
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         loop_reg <= 4'h0;
         ret_reg <= 6'h00;
      end else if (exec) begin
         if (op == cipher_seq_pkg::OP_LOOP_LOAD) begin
            loop_reg <= third_b[3:0];
         end else if (op == cipher_seq_pkg::OP_LOOP_DEC) begin
            loop_reg <= loop_dec;
         end
         if (op == cipher_seq_pkg::OP_CALL) begin
            ret_reg <= pc_inc;
         end
      end
   end

   // Program RAM loaded by software, address auto-increments
   always_ff @(posedge clk_i) begin
      if (wr_ram_data) begin
         ram_mem[ram_addr_reg] <= wdata_i[21:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ram_addr_reg <= 5'h00;
         run_reg <= 1'b0;
         config_reg <= 8'h00;
         rdata_reg <= 32'h00000000;
      end else begin
         if (wr_ram_addr) begin
            ram_addr_reg <= wdata_i[4:0];
         end else if (wr_ram_data) begin
            ram_addr_reg <= ram_addr_reg + 5'h01;
         end
         if (wr_control) begin
            run_reg <= wdata_i[cipher_seq_pkg::CTL_RUN];
         end
         if (wr_config) begin
            config_reg <= wdata_i[7:0];
         end
         rdata_reg <= rd_i ? read_mux : 32'h00000000;
      end
   end

   // Handshake flags; any set wins over a same-cycle clear
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         in_full_reg <= 1'b0;
         out_empty_reg <= 1'b1;
      end else begin
         if (in_reg_write_i || force_flags) begin
            in_full_reg <= 1'b1;
         end else if (cc_exec && first_b[cipher_seq_pkg::CC_IN_CLEAR]) begin
            in_full_reg <= 1'b0;
         end
         if (out_reg_read_i || force_flags) begin
            out_empty_reg <= 1'b1;
         end else if (cc_exec && second_b[cipher_seq_pkg::CC_OUT_CLEAR]) begin
            out_empty_reg <= 1'b0;
         end
      end
   end

   // Sticky decode errors, cleared by writing one; a new error wins
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mux_err_reg <= 1'b0;
         cfb_err_reg <= 1'b0;
      end else begin
         if (mux_bad) begin
            mux_err_reg <= 1'b1;
         end else if (wr_status && wdata_i[cipher_seq_pkg::ST_MUX_ERR]) begin
            mux_err_reg <= 1'b0;
         end
         if (cfb_bad) begin
            cfb_err_reg <= 1'b1;
         end else if (wr_status && wdata_i[cipher_seq_pkg::ST_CFB_ERR]) begin
            cfb_err_reg <= 1'b0;
         end
      end
   end

   // Select form: selects held until the next select instruction
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         strobe_reg <= 11'h000;
         msel_reg <= 13'h0000;
      end else begin
         strobe_reg <= strobe_next;
         if (ms_exec) begin
            msel_reg <= {first_b[cipher_seq_pkg::MS_ONE], two_sel,
               first_b[cipher_seq_pkg::MS_THREE], first_b[cipher_seq_pkg::MS_FOUR],
               five_sel, six_sel, thirteen_sel, 2'h0};
         end
      end
   end

   // Control bits set by argument operations, all dropped by clear
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rot_right_reg <= 1'b0;
         rot_left_reg <= 1'b0;
         pair_reg <= 2'h0;
         int_sel_reg <= 1'b0;
         cfb_reg <= 2'h0;
         serial_reg <= 1'b0;
         master_reg <= 1'b0;
         engaged_reg <= 1'b0;
      end else if (is_clear) begin
         rot_right_reg <= 1'b0;
         rot_left_reg <= 1'b0;
         pair_reg <= 2'h0;
         int_sel_reg <= 1'b0;
         cfb_reg <= 2'h0;
         serial_reg <= 1'b0;
         master_reg <= 1'b0;
         engaged_reg <= 1'b0;
      end else if (is_rot) begin
         rot_right_reg <= third_b[cipher_seq_pkg::ARG_ROT_RIGHT];
         rot_left_reg <= !third_b[cipher_seq_pkg::ARG_ROT_RIGHT];
      end else if (is_pair) begin
         pair_reg <= third_b[cipher_seq_pkg::ARG_PAIR_HI:cipher_seq_pkg::ARG_PAIR_LO];
         int_sel_reg <= third_b[cipher_seq_pkg::ARG_INT_SEL];
      end else if (is_io) begin
         cfb_reg <= cfb_arg;
         serial_reg <= third_b[cipher_seq_pkg::ARG_SERIAL];
         master_reg <= third_b[cipher_seq_pkg::ARG_MASTER];
         engaged_reg <= third_b[cipher_seq_pkg::ARG_ENGAGED];
      end
   end

   assign rdata_o = rdata_reg;
   assign in_full_flag_o = in_full_reg;
   assign out_empty_flag_o = out_empty_reg;
   assign cipher_src_sel_o = strobe_reg[10];
   assign cipher_lr_clock_o = strobe_reg[9];
   assign latch_clock_o = strobe_reg[8];
   assign double_rotate_o = strobe_reg[7];
   assign key_reg_latch_o = strobe_reg[6];
   assign key_cd_load_o = strobe_reg[5];
   assign key_cd_clock_o = strobe_reg[4];
   assign out_reg_clock_o = strobe_reg[1];
   assign store_iv_o = strobe_reg[0];
   assign rot_right_o = rot_right_reg;
   assign rot_left_o = rot_left_reg;
   assign mux_one_sel_o = msel_reg[12];
   assign mux_two_sel_o = msel_reg[11:10];
   assign mux_three_sel_o = msel_reg[9];
   assign mux_four_sel_o = msel_reg[8];
   assign mux_five_sel_o = msel_reg[7:6];
   assign mux_six_sel_o = msel_reg[5:4];
   assign mux_thirteen_sel_o = msel_reg[3:2];
   // Pair from microcode or from software config bits
   assign pair_addr_o = int_sel_reg ? pair_reg : config_reg[1:0];
   assign internal_addr_sel_o = int_sel_reg;
   assign cfb_width_o = cfb_reg;
   assign serial_key_o = serial_reg;
   assign force_master_input_o = master_reg;
   assign engaged_o = engaged_reg;
   assign error_o = mux_err_reg || cfb_err_reg;
   assign pc_o = pc_reg;

endmodule : cipher_microsequencer_decoder

// *** tb/cipher_microsequencer_decoder_props.sv ***
module cipher_microsequencer_decoder_props (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic in_reg_write_i,
   input wire logic out_reg_read_i,
   input wire logic in_full_flag_o,
   input wire logic out_empty_flag_o,
   input wire logic cipher_lr_clock_o,
   input wire logic key_reg_latch_o,
   input wire logic rot_right_o,
   input wire logic rot_left_o,
   input wire logic [1:0] mux_two_sel_o,
   input wire logic [1:0] mux_six_sel_o,
   input wire logic [1:0] cfb_width_o,
   input wire logic error_o,
   input wire logic [5:0] pc_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not zero outside read slot");
   // A START write may move the counter early, so it is excluded
   chk_pc_two_cycles: assert property (($changed(pc_o) && !wr_i) |=> $stable(pc_o))
      else $error("counter held less than two cycles");
   chk_lr_pulse: assert property (cipher_lr_clock_o |=> !cipher_lr_clock_o)
      else $error("L/R clock longer than one cycle");
   chk_key_pulse: assert property (key_reg_latch_o |=> !key_reg_latch_o)
      else $error("key latch longer than one cycle");
   chk_in_set: assert property (in_reg_write_i |=> in_full_flag_o)
      else $error("input full not set by host write");
   chk_in_fall: assert property ($fell(in_full_flag_o) |-> !$past(in_reg_write_i))
      else $error("input full cleared against host write");
   chk_out_set: assert property (out_reg_read_i |=> out_empty_flag_o)
      else $error("output empty not set by host read");
   // Illegal codes still load the selects, so the error must come with them
   chk_sel_err: assert property (((mux_two_sel_o == 2'h3) || (mux_six_sel_o == 2'h3)) &&
      ($changed(mux_two_sel_o) || $changed(mux_six_sel_o)) |-> error_o)
      else $error("illegal select loaded without error");
   chk_rot_excl: assert property (!(rot_right_o && rot_left_o))
      else $error("both rotation directions latched");
   chk_cfb_legal: assert property (cfb_width_o != 2'h3)
      else $error("illegal feedback width");
endmodule : cipher_microsequencer_decoder_props

bind cipher_microsequencer_decoder cipher_microsequencer_decoder_props i_props (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .in_reg_write_i(in_reg_write_i), .out_reg_read_i(out_reg_read_i),
   .in_full_flag_o(in_full_flag_o), .out_empty_flag_o(out_empty_flag_o),
   .cipher_lr_clock_o(cipher_lr_clock_o), .key_reg_latch_o(key_reg_latch_o),
   .rot_right_o(rot_right_o), .rot_left_o(rot_left_o), .mux_two_sel_o(mux_two_sel_o),
   .mux_six_sel_o(mux_six_sel_o), .cfb_width_o(cfb_width_o), .error_o(error_o),
   .pc_o(pc_o));

// *** tb/host_port_model.sv ***
module host_port_model (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic fill_req_i,
   input wire logic drain_req_i,
   input wire logic in_full_flag_i,
   input wire logic out_empty_flag_i,
   output logic in_reg_write_o,
   output logic out_reg_read_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Host only touches a register its flag frees; one pulse per request
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         in_reg_write_o <= 1'b0;
         out_reg_read_o <= 1'b0;
      end else begin
         in_reg_write_o <= fill_req_i && !in_full_flag_i && !in_reg_write_o;
         out_reg_read_o <= drain_req_i && !out_empty_flag_i && !out_reg_read_o;
      end
   end
endmodule : host_port_model

// *** tb/cipher_microsequencer_decoder_bench.sv ***
module cipher_microsequencer_decoder_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0, rd = 1'b0, fill_req = 1'b0, drain_req = 1'b0;
   logic in_wr, out_rd, in_full, out_empty, rot_r, rot_l, m1, m3, m4, isel, eng, err;
   logic [1:0] m2, m5, m6, m13, pair, cfb;
   logic [31:0] rdata;
   logic [5:0] pc;
   logic [31:0] seed = 32'hdb577310;
   logic [5:0] trace[$];
   int error_cnt = 0;
   int total_checks = 0;
   // Program at 20: clear, io mode, strobes, selects, loop, call, halt, subroutine
   localparam logic [21:0] PROG [12] = '{22'h300, 22'h2e9, 22'h1247c0, 22'h26bbc0, 22'h403,
      22'h465, 22'h4a9, 22'h527, 22'h7c0, 22'h641, 22'h685, 22'h4c0};
   localparam logic [5:0] TRACE [10] = '{6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h29,
      6'h2a, 6'h2b, 6'h27};
   // Flag test at 36: clear both flags, park, branch, two parking spots
   localparam logic [21:0] BR [5] = '{22'h67c0, 22'h537, 22'h7c0, 22'h539, 22'h53a};

   always #5 clk_i = ~clk_i;

   cipher_microsequencer_decoder i_dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .in_reg_write_i(in_wr), .out_reg_read_i(out_rd),
      .in_full_flag_o(in_full), .out_empty_flag_o(out_empty), .cipher_src_sel_o(),
      .cipher_lr_clock_o(), .latch_clock_o(), .double_rotate_o(), .key_reg_latch_o(),
      .key_cd_load_o(), .key_cd_clock_o(), .out_reg_clock_o(), .store_iv_o(),
      .rot_right_o(rot_r), .rot_left_o(rot_l), .mux_one_sel_o(m1), .mux_two_sel_o(m2),
      .mux_three_sel_o(m3), .mux_four_sel_o(m4), .mux_five_sel_o(m5), .mux_six_sel_o(m6),
      .mux_thirteen_sel_o(m13), .pair_addr_o(pair), .internal_addr_sel_o(isel),
      .cfb_width_o(cfb), .serial_key_o(), .force_master_input_o(), .engaged_o(eng),
      .error_o(err), .pc_o(pc));

   host_port_model i_host (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .fill_req_i(fill_req), .drain_req_i(drain_req),
      .in_full_flag_i(in_full), .out_empty_flag_i(out_empty), .in_reg_write_o(in_wr),
      .out_reg_read_o(out_rd));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict

   // Gap cycle after each strobe keeps drivers from double assignment
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      @(posedge clk_i);
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(negedge clk_i);
      check(rdata, exp);
      @(posedge clk_i);
   endtask : bus_rd

   task automatic run_to(input logic [5:0] p, output int n);
      n = 0;
      // Counter looked at mid-cycle, where it has settled
      while (pc !== p && n < 300) begin
         @(negedge clk_i);
         n++;
         if (pc !== trace[$]) trace.push_back(pc);
      end
      @(posedge clk_i);
      if (n >= 300) check(32'h1, 32'h0);
   endtask : run_to

   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      print_verdict();
   end

   initial begin : main
      logic [31:0] r;
      logic [7:0] f, s;
      logic ill, j;
      int n;
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      bus_wr(cipher_seq_pkg::REG_RAM_ADDR, 32'h0);
      foreach (PROG[i]) bus_wr(cipher_seq_pkg::REG_RAM_DATA, {10'h0, PROG[i]});
      bus_wr(cipher_seq_pkg::REG_START, 32'h20);
      bus_wr(cipher_seq_pkg::REG_CONTROL, 32'h1);
      trace = {pc};
      run_to(6'h21, n);
      trace = {pc};
      run_to(6'h27, n);
      check(n, 32'd22);
      check(trace.size(), 32'd10);
      foreach (TRACE[i]) check(trace[i], TRACE[i]);
      check({eng, cfb, rot_r, rot_l}, 5'b1_10_10);
      check({pair, isel, in_full, out_empty}, 5'b10_1_01);
      check({m1, m2, m3, m4, m5, m6, m13}, 11'b1_00_1_1_01_01_11);
      bus_rd(cipher_seq_pkg::REG_STATUS, 32'h2745);
      bus_rd(8'h1c, 32'h0);
      for (int k = 0; k < 8; k++) begin
         r = xs();
         f = r[7:0];
         if (k == 0) f[6:5] = 2'h3;
         s = {r[15:13], 5'h04};
         bus_wr(cipher_seq_pkg::REG_RAM_ADDR, 32'h10);
         bus_wr(cipher_seq_pkg::REG_RAM_DATA, {10'h0, f, s, 6'h30});
         bus_wr(cipher_seq_pkg::REG_START, 32'h30);
         repeat (4) @(posedge clk_i);
         bus_wr(cipher_seq_pkg::REG_STATUS, 32'h30);
         repeat (3) @(posedge clk_i);
         ill = f[6:5] == 2'h3 || f[2:1] == 2'h3 || {f[0], s[7]} == 2'h3;
         check(err, ill);
         if (!ill) check({m1, m2, m3, m4, m5, m6, m13}, {f, s[7:5]});
      end
      bus_wr(cipher_seq_pkg::REG_RAM_ADDR, 32'h16);
      foreach (BR[i]) bus_wr(cipher_seq_pkg::REG_RAM_DATA, {10'h0, BR[i]});
      for (int op = 5; op < 9; op++) begin
         for (int fl = 0; fl < 4; fl++) begin
            r = xs();
            bus_wr(cipher_seq_pkg::REG_CONFIG, {24'h0, r[7], 7'h0});
            bus_wr(cipher_seq_pkg::REG_RAM_ADDR, 32'h18);
            bus_wr(cipher_seq_pkg::REG_RAM_DATA, {22'h1, op[3:0], 6'h3a});
            bus_wr(cipher_seq_pkg::REG_START, 32'h36);
            repeat (4) @(posedge clk_i);
            fill_req <= fl[0];
            drain_req <= fl[1];
            repeat (4) @(posedge clk_i);
            fill_req <= 1'b0;
            drain_req <= 1'b0;
            bus_wr(cipher_seq_pkg::REG_START, 32'h38);
            repeat (4) @(posedge clk_i);
            check({in_full, out_empty}, {fl[0], fl[1]});
            case (op)
               5: j = !fl[0];
               6: j = !fl[1];
               7: j = fl[0] && fl[1];
               default: j = !r[7];
            endcase
            check(pc, j ? 6'h3a : 6'h39);
         end
      end
      print_verdict();
   end
endmodule : cipher_microsequencer_decoder_bench
